// ==== hdl/scr_config_regs.sv ====
// Configuration register bank with field decode for the amplifier
`timescale 1ns/10ps
`default_nettype none
module scr_config_regs (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        wr_en_in,
    input  wire logic [7:0]  wr_data_in,
    output logic      [7:0]  rd_data_out,
    input  wire logic        battery_mode_in,
    input  wire logic [3:0]  battery_high_side_switch_speed_in,
    output logic      [3:0]  low_side_switch_speed_out,
    output logic      [3:0]  power_stage_high_side_switch_speed_out,
    output logic      [3:0]  rise_speed_out,
    output logic      [4:0]  clip_gain_half_db_out,
    output logic             clip_gain_reserved_out,
    output logic             bypass_wide_filter_on_out,
    output logic             bypass_polarity_flip_out,
    input  wire logic [15:0] bypass_sample_in,
    output logic      [15:0] bypass_sample_out,
    output logic             path_feedback_output_on_out,
    output logic             speaker_path_on_out,
    output logic      [1:0]  high_rail_channel_rate_out,
    output logic      [1:0]  thermal_channel_rate_out,
    output logic      [1:0]  power_stage_channel_rate_out,
    output logic      [1:0]  battery_channel_rate_out,
    output logic             power_stage_channel_filter_on_out,
    output logic      [3:0]  power_stage_channel_filter_bandwidth_out,
    output logic             filter_setting_valid_out
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]  slew;
        logic [7:0]  gain;
        logic [7:0]  bypass;
        logic [7:0]  enables;
        logic [7:0]  rates;
        logic [7:0]  filter;
        logic [15:0] byp_out;
    } scr_state_t;

    scr_state_t state_reg;
    scr_state_t state_next;

    logic [3:0] bw_code;
    logic [1:0] ps_rate;
    logic [3:0] gain_code;

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        if (wr_en_in) begin
            // Masked so unused bits stay zero
            case (addr_in)
                scr_pkg::SCR_OFS_SLEW:
                    state_next.slew = wr_data_in & scr_pkg::SCR_MSK_SLEW;
                scr_pkg::SCR_OFS_GAIN:
                    state_next.gain = wr_data_in & scr_pkg::SCR_MSK_GAIN;
                scr_pkg::SCR_OFS_BYPASS:
                    state_next.bypass = wr_data_in & scr_pkg::SCR_MSK_BYPASS;
                scr_pkg::SCR_OFS_ENABLES:
                    state_next.enables = wr_data_in & scr_pkg::SCR_MSK_ENABLES;
                scr_pkg::SCR_OFS_RATES:
                    state_next.rates = wr_data_in & scr_pkg::SCR_MSK_RATES;
                scr_pkg::SCR_OFS_FILTER:
                    state_next.filter = wr_data_in & scr_pkg::SCR_MSK_FILTER;
                default: ;
            endcase
        end
        // Bypass data registered; negated when polarity flip is set
        if (state_reg.bypass[scr_pkg::SCR_POS_FLIP])
            state_next.byp_out = 16'(-bypass_sample_in);
        else
            state_next.byp_out = bypass_sample_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg.slew    <= scr_pkg::SCR_RST_SLEW;
            state_reg.gain    <= scr_pkg::SCR_RST_GAIN;
            state_reg.bypass  <= scr_pkg::SCR_RST_BYPASS;
            state_reg.enables <= scr_pkg::SCR_RST_ENABLES;
            state_reg.rates   <= scr_pkg::SCR_RST_RATES;
            state_reg.filter  <= scr_pkg::SCR_RST_FILTER;
            state_reg.byp_out <= 16'h0000;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Readback, unmapped addresses read zero
    always_comb begin
        case (addr_in)
            scr_pkg::SCR_OFS_SLEW:    rd_data_out = state_reg.slew;
            scr_pkg::SCR_OFS_GAIN:    rd_data_out = state_reg.gain;
            scr_pkg::SCR_OFS_BYPASS:  rd_data_out = state_reg.bypass;
            scr_pkg::SCR_OFS_ENABLES: rd_data_out = state_reg.enables;
            scr_pkg::SCR_OFS_RATES:   rd_data_out = state_reg.rates;
            scr_pkg::SCR_OFS_FILTER:  rd_data_out = state_reg.filter;
            default:                  rd_data_out = 8'h00;
        endcase
    end

    // ==========================================================
    // Field outputs
    // Speed codes pass raw: 0 slowest, all-ones fastest
    assign low_side_switch_speed_out =
        state_reg.slew[scr_pkg::SCR_POS_LS +: 4];
    assign power_stage_high_side_switch_speed_out =
        state_reg.slew[scr_pkg::SCR_POS_HS +: 4];
    // Rise edge follows whichever rail feeds the stage
    assign rise_speed_out = battery_mode_in ?
        battery_high_side_switch_speed_in :
        power_stage_high_side_switch_speed_out;

    assign gain_code = state_reg.gain[3:0];
    always_comb begin
        clip_gain_reserved_out = 1'b0;
        if (gain_code <= scr_pkg::SCR_GAIN_HALF)
            clip_gain_half_db_out = {1'b0, gain_code};
        else if (gain_code == scr_pkg::SCR_GAIN_HALF + 4'h1)
            clip_gain_half_db_out = scr_pkg::SCR_GAIN_5DB;
        else if (gain_code == scr_pkg::SCR_GAIN_MAX)
            clip_gain_half_db_out = scr_pkg::SCR_GAIN_6DB;
        else begin
            // Reserved codes fall back to unity gain
            clip_gain_half_db_out = 5'h00;
            clip_gain_reserved_out = 1'b1;
        end
    end

    assign bypass_wide_filter_on_out =
        state_reg.bypass[scr_pkg::SCR_POS_WIDE];
    assign bypass_polarity_flip_out =
        state_reg.bypass[scr_pkg::SCR_POS_FLIP];
    assign bypass_sample_out = state_reg.byp_out;
    assign path_feedback_output_on_out =
        state_reg.enables[scr_pkg::SCR_POS_FB];
    assign speaker_path_on_out =
        state_reg.enables[scr_pkg::SCR_POS_PATH];

    assign high_rail_channel_rate_out =
        state_reg.rates[scr_pkg::SCR_POS_HIGH_SR +: 2];
    assign thermal_channel_rate_out =
        state_reg.rates[scr_pkg::SCR_POS_THERM_SR +: 2];
    assign power_stage_channel_rate_out =
        state_reg.rates[scr_pkg::SCR_POS_PS_SR +: 2];
    assign battery_channel_rate_out =
        state_reg.rates[scr_pkg::SCR_POS_BAT_SR +: 2];

    assign power_stage_channel_filter_on_out =
        state_reg.filter[scr_pkg::SCR_POS_FILT_ON];
    assign bw_code = state_reg.filter[scr_pkg::SCR_POS_FILT_BW +: 4];
    assign power_stage_channel_filter_bandwidth_out = bw_code;
    assign ps_rate = power_stage_channel_rate_out;

    // Flags bandwidth codes that the present power stage channel rate can support
    always_comb begin
        if (bw_code <= scr_pkg::SCR_BW_ANY_MAX)
            filter_setting_valid_out = 1'b1;
        else if (bw_code == scr_pkg::SCR_BW_50K)
            filter_setting_valid_out = (ps_rate == scr_pkg::SCR_SR_300K) ||
                (ps_rate == scr_pkg::SCR_SR_150K);
        else if (bw_code == scr_pkg::SCR_BW_150K)
            filter_setting_valid_out =
                (ps_rate == scr_pkg::SCR_SR_300K);
        else
            filter_setting_valid_out = 1'b0;
    end
endmodule // scr_config_regs
`default_nettype wire

// ==== hdl/scr_pkg.sv ====
// Constants for the speaker and measurement converter configuration bank
package scr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [15:0] SCR_OFS_SLEW    = 16'h209d;
    localparam logic [15:0] SCR_OFS_GAIN    = 16'h209e;
    localparam logic [15:0] SCR_OFS_BYPASS  = 16'h209f;
    localparam logic [15:0] SCR_OFS_ENABLES = 16'h20af;
    localparam logic [15:0] SCR_OFS_RATES   = 16'h20b0;
    localparam logic [15:0] SCR_OFS_FILTER  = 16'h20b1;
    // ==========================================================
    // Writable bit masks
    localparam logic [7:0] SCR_MSK_SLEW    = 8'hff;
    localparam logic [7:0] SCR_MSK_GAIN    = 8'h0f;
    localparam logic [7:0] SCR_MSK_BYPASS  = 8'h03;
    localparam logic [7:0] SCR_MSK_ENABLES = 8'h03;
    localparam logic [7:0] SCR_MSK_RATES   = 8'hff;
    localparam logic [7:0] SCR_MSK_FILTER  = 8'h1f;
    // ==========================================================
    // Reset values
    localparam logic [7:0] SCR_RST_SLEW    = 8'hfc;
    localparam logic [7:0] SCR_RST_GAIN    = 8'h00;
    localparam logic [7:0] SCR_RST_BYPASS  = 8'h00;
    localparam logic [7:0] SCR_RST_ENABLES = 8'h00;
    localparam logic [7:0] SCR_RST_RATES   = 8'h30;
    localparam logic [7:0] SCR_RST_FILTER  = 8'h00;
    // ==========================================================
    // Field positions
    localparam int SCR_POS_LS       = 4;
    localparam int SCR_POS_HS       = 0;
    localparam int SCR_POS_WIDE     = 1;
    localparam int SCR_POS_FLIP     = 0;
    localparam int SCR_POS_FB       = 1;
    localparam int SCR_POS_PATH     = 0;
    localparam int SCR_POS_HIGH_SR  = 6;
    localparam int SCR_POS_THERM_SR = 4;
    localparam int SCR_POS_PS_SR    = 2;
    localparam int SCR_POS_BAT_SR   = 0;
    localparam int SCR_POS_FILT_ON  = 4;
    localparam int SCR_POS_FILT_BW  = 0;
    // ==========================================================
    // Decode limits
    localparam logic [3:0] SCR_GAIN_MAX   = 4'ha;
    localparam logic [3:0] SCR_GAIN_HALF  = 4'h8;
    localparam logic [3:0] SCR_BW_ANY_MAX = 4'h2;
    localparam logic [3:0] SCR_BW_50K     = 4'h3;
    localparam logic [3:0] SCR_BW_150K    = 4'h4;
    localparam logic [1:0] SCR_SR_300K    = 2'h0;
    localparam logic [1:0] SCR_SR_150K    = 2'h1;
    // Gain in half-dB units for codes above the linear range
    localparam logic [4:0] SCR_GAIN_5DB   = 5'h0a;
    localparam logic [4:0] SCR_GAIN_6DB   = 5'h0c;
endpackage

// ==== tb/scr_props.sv ====
// Port checker for the configuration register bank
`timescale 1ns/10ps
`default_nettype none
module scr_props (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [15:0] addr_in,
    input wire logic        wr_en_in,
    input wire logic [7:0]  wr_data_in,
    input wire logic [7:0]  rd_data_out,
    input wire logic [3:0]  low_side_switch_speed_out,
    input wire logic [4:0]  clip_gain_half_db_out,
    input wire logic        clip_gain_reserved_out,
    input wire logic        bypass_polarity_flip_out,
    input wire logic [15:0] bypass_sample_in,
    input wire logic [15:0] bypass_sample_out,
    input wire logic        path_feedback_output_on_out,
    input wire logic        speaker_path_on_out,
    input wire logic [1:0]  thermal_channel_rate_out
);
    logic wr_slew;
    logic wr_gain;
    logic wr_ens;
    assign wr_slew = wr_en_in && addr_in == scr_pkg::SCR_OFS_SLEW;
    assign wr_gain = wr_en_in && addr_in == scr_pkg::SCR_OFS_GAIN;
    assign wr_ens = wr_en_in && addr_in == scr_pkg::SCR_OFS_ENABLES;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // ==========================================================
    // Properties
    property p_slew_wr; wr_slew |=> low_side_switch_speed_out == $past(wr_data_in[7:4]); endproperty
    a_slew_wr: assert property (p_slew_wr) else $error("low side speed not written");
    property p_flip; ##1 bypass_sample_out == ($past(bypass_polarity_flip_out) ? -$past(bypass_sample_in) : $past(bypass_sample_in)); endproperty
    a_flip: assert property (p_flip) else $error("bypass sample polarity wrong");
    property p_gain_rsv; clip_gain_reserved_out |-> clip_gain_half_db_out == 5'h00; endproperty
    a_gain_rsv: assert property (p_gain_rsv) else $error("reserved gain not zero");
    property p_gain_wr; wr_gain && wr_data_in[3:0] == 4'h9 |=> clip_gain_half_db_out == 5'h0a; endproperty
    a_gain_wr: assert property (p_gain_wr) else $error("gain code 9 decode wrong");
    property p_unmapped; !(addr_in inside {[16'h209d:16'h209f], [16'h20af:16'h20b1]}) |-> rd_data_out == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_en_wr; wr_ens |=> speaker_path_on_out == $past(wr_data_in[0]); endproperty
    a_en_wr: assert property (p_en_wr) else $error("path enable not written");
    property p_en_hold; !wr_ens |=> $stable(speaker_path_on_out); endproperty
    a_en_hold: assert property (p_en_hold) else $error("path enable changed");
    property p_fb_wr; wr_ens |=> path_feedback_output_on_out == $past(wr_data_in[1]); endproperty
    a_fb_wr: assert property (p_fb_wr) else $error("feedback enable wrong");
    property p_rate_rd; addr_in == scr_pkg::SCR_OFS_RATES |-> rd_data_out[5:4] == thermal_channel_rate_out; endproperty
    a_rate_rd: assert property (p_rate_rd) else $error("thermal rate readback wrong");
endmodule // scr_props
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        wr_en_in = 1'b0;
    logic        battery_mode_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic [15:0] bypass_sample_in = 16'h0000;
    logic [7:0]  wr_data_in = 8'h00;
    logic [3:0]  battery_high_side_switch_speed_in = 4'h0;
    logic [7:0]  rd_data_out;
    logic [3:0]  low_side_switch_speed_out, rise_speed_out;
    logic [3:0]  power_stage_high_side_switch_speed_out;
    logic [3:0]  power_stage_channel_filter_bandwidth_out;
    logic [4:0]  clip_gain_half_db_out;
    logic [15:0] bypass_sample_out;
    logic [1:0]  high_rail_channel_rate_out, thermal_channel_rate_out;
    logic [1:0]  power_stage_channel_rate_out, battery_channel_rate_out;
    logic        clip_gain_reserved_out, bypass_wide_filter_on_out;
    logic        bypass_polarity_flip_out, path_feedback_output_on_out;
    logic        speaker_path_on_out, power_stage_channel_filter_on_out;
    logic        filter_setting_valid_out;
    int          n_errors = 0;
    int          check_count = 0;
    logic [15:0] ofs [6] = '{16'h209d, 16'h209e, 16'h209f,
                             16'h20af, 16'h20b0, 16'h20b1};
    logic [7:0]  rstv [6] = '{8'hfc, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00};
    logic [7:0]  msk [6] = '{8'hff, 8'h0f, 8'h03, 8'h03, 8'hff, 8'h1f};
    scr_config_regs u_dut (.*);
    always #5 clk_in = ~clk_in;
    // ==========================================================
    // Expectations and bus tasks
    function automatic logic [4:0] gain_exp(input logic [3:0] c);
        return (c <= 4'h8) ? {1'b0, c} : (c == 4'h9) ? 5'h0a :
               (c == 4'ha) ? 5'h0c : 5'h00;
    endfunction
    function automatic logic valid_exp(input logic [3:0] b, logic [1:0] r);
        return b <= 4'h2 || (b == 4'h3 && r <= 2'h1) || (b == 4'h4 && r == 2'h0);
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        #1;
        chk("readback", {8'h00, e}, {8'h00, rd_data_out});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        logic [7:0] d;
        void'($urandom(32'h16bd_59e1));
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 6; i++) rd(ofs[i], rstv[i]);
        $display("test reset_values finished");
        repeat (10) for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            wr(ofs[i], d);
            rd(ofs[i], d & msk[i]);
            wr(16'h20a0 + 16'(i), d);
            rd(16'h20a0 + 16'(i), 8'h00);
        end
        wr(ofs[0], d);
        chk("slew", 16'(d), {low_side_switch_speed_out, power_stage_high_side_switch_speed_out});
        wr(ofs[4], d);
        chk("rates", 16'(d), {high_rail_channel_rate_out, thermal_channel_rate_out, power_stage_channel_rate_out, battery_channel_rate_out});
        $display("test random_access finished");
        for (int c = 0; c < 16; c++) begin
            wr(ofs[1], {4'($urandom), 4'(c)});
            chk("gain", 16'(gain_exp(4'(c))), 16'(clip_gain_half_db_out));
            chk("gain_reserved", 16'(c > 10), 16'(clip_gain_reserved_out));
        end
        for (int k = 0; k < 64; k++) begin
            wr(ofs[4], {4'h0, 2'(k >> 4), 2'h0});
            wr(ofs[5], {3'h0, 5'(k)});
            chk("filter_valid", 16'(valid_exp(4'(k), 2'(k >> 4))), 16'(filter_setting_valid_out));
            chk("filter", 16'(k & 31), {11'h000, power_stage_channel_filter_on_out, power_stage_channel_filter_bandwidth_out});
        end
        for (int k = 0; k < 4; k++) begin
            wr(ofs[3], 8'(k));
            chk("enables", 16'(k), {path_feedback_output_on_out, speaker_path_on_out});
            wr(ofs[2], 8'(k));
            chk("bypass_bits", 16'(k), {bypass_wide_filter_on_out, bypass_polarity_flip_out});
            repeat (8) begin
                @(posedge clk_in);
                bypass_sample_in <= 16'($urandom);
                battery_mode_in <= 1'($urandom);
                battery_high_side_switch_speed_in <= 4'($urandom);
                #1;
                chk("rise", 16'(battery_mode_in ? battery_high_side_switch_speed_in : d[3:0]), 16'(rise_speed_out));
                @(posedge clk_in);
                #1;
                chk("bypass_sample", k[0] ? -bypass_sample_in : bypass_sample_in, bypass_sample_out);
            end
        end
        $display("test decode finished");
        wr(ofs[0], 8'h00);
        // Quiet bypass input so the registered sample matches after reset
        bypass_sample_in <= 16'h0000;
        rst_n_in <= 1'b0;
        #1;
        chk("slew_after_reset", 16'h00fc, {low_side_switch_speed_out, power_stage_high_side_switch_speed_out});
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(ofs[0], 8'hfc);
        $display("test mid_reset finished");
        summarize();
    end
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
endmodule // tb_top
bind scr_config_regs scr_props u_props (.*);
`default_nettype wire
